// ==== logic/tsm_top.sv ====
/*
 * Thermal monitor block in the host bus unit: register window,
 * converter clocking, offset addition and threshold comparison.
 * Assumes a simple synchronous register port (one-cycle read data)
 * and a converter that returns a raw sample with a done strobe.
 */
`timescale 1ns/1ps
// Functional notes
// RULE1: Converter clock is source divided by 1024, then by programmable divider.
// RULE2: Wide divider field holds value shifted right 4; bypass allowed.
// RULE3: Divider field is status bits 25-31 narrow, 26-31 wide.
// RULE4: Narrow source is host clock; wide source is constant-rate clock.
// RULE5: Reported reading is raw value plus signed offset.
// RULE6: Threshold bits 0-7 or 0-13, offset bits 16-23 or 16-29.
// RULE7: Software clears disable and hold, sets enable and attach.
// RULE8: Wide: software never sets disable and enable together.
// RULE9: Interrupt 16 while reading exceeds alarm threshold.
// RULE10: Narrow: alarm interrupt only while bit 28 is set.
// RULE11: Status alarm flag follows reading above threshold, no hysteresis.
// RULE12: Interrupt 17 while reading below range low threshold.
// RULE13: Interrupt 18 while reading above range high threshold.
// RULE14: Range comparisons have no hysteresis.
// RULE15: Range low/high at bits 0-7/8-15 or 0-13/16-29.
// RULE16: Registers occupy 0x15b0 to below 0x15c0.
// RULE17: Software keeps converter clock below 10 kHz.
// RULE18: Flags update in the cycle the new reading is stored.
// RULE19: Offset sign-extended, sum wraps to reading width.
module tsm_top #(
   parameter bit WIDE = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic host_tick,
   input wire logic const_tick,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_hit,
   output logic adc_clk_en,
   output logic adc_run,
   output logic adc_attach,
   input wire logic adc_done,
   input wire logic [13:0] adc_raw,
   output logic irq_alarm,
   output logic irq_range_low,
   output logic irq_range_high
);
   localparam int RW = WIDE ? tsm_pkg::W_WIDTH : tsm_pkg::N_WIDTH;

   // ------------------------------------------------------------
   // Field extraction
   // ------------------------------------------------------------
   function automatic logic [13:0] field_at(input logic [31:0] w, input int lsb);
      logic [31:0] s;
      s = w >> lsb;
      field_at = (RW == tsm_pkg::W_WIDTH) ? s[13:0] : {6'h00, s[7:0]};
   endfunction

   function automatic logic signed [14:0] sfield(input logic [13:0] v);
      sfield = (RW == tsm_pkg::W_WIDTH) ? $signed({v[13], v})
         : $signed({{7{v[7]}}, v[7:0]});
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] alarm_cfg_r;
   logic [31:0] misc_cfg_r;
   logic [31:0] temp_win_r;
   logic [6:0] div_field_r;
   logic [13:0] reading_r;
   logic alarm_r;
   logic low_r;
   logic high_r;
   logic [31:0] status_word;
   logic in_window;

   assign in_window = (reg_addr & tsm_pkg::ADDR_WIN_MASK) == tsm_pkg::ADDR_ALARM_CFG; // [RULE16]
   assign reg_hit = in_window && (reg_wr || reg_rd);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         alarm_cfg_r <= 32'h0000_0000;
         misc_cfg_r <= 32'h0000_0000;
         temp_win_r <= 32'h0000_0000;
      end else if (reg_wr) begin
         case (reg_addr)
            tsm_pkg::ADDR_ALARM_CFG: alarm_cfg_r <= reg_wdata; // [RULE6]
            tsm_pkg::ADDR_MISC_CFG: misc_cfg_r <= reg_wdata;
            tsm_pkg::ADDR_TEMP_WIN: temp_win_r <= reg_wdata; // [RULE15]
            default: ;
         endcase
      end
   end

   // Only the divider field of status is writable; the rest is state
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         div_field_r <= WIDE ? {1'b0, tsm_pkg::W_DIV_RESET} : tsm_pkg::N_DIV_RESET;
      end else if (reg_wr && reg_addr == tsm_pkg::ADDR_STATUS) begin
         if (WIDE) begin
            div_field_r <= {1'b0, reg_wdata[tsm_pkg::W_DIV_LSB +: tsm_pkg::W_DIV_W]}; // [RULE3]
         end else begin
            div_field_r <= reg_wdata[tsm_pkg::N_DIV_LSB +: tsm_pkg::N_DIV_W]; // [RULE3]
         end
      end
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[13:0] = reading_r;
      if (WIDE) begin
         status_word[tsm_pkg::W_ALARM_STAT_BIT] = alarm_r; // [RULE11]
         status_word[tsm_pkg::W_DIV_LSB +: tsm_pkg::W_DIV_W] = div_field_r[5:0];
      end else begin
         status_word[tsm_pkg::N_ALARM_STAT_BIT] = alarm_r; // [RULE11]
         status_word[tsm_pkg::N_DIV_LSB +: tsm_pkg::N_DIV_W] = div_field_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            tsm_pkg::ADDR_ALARM_CFG: reg_rdata <= alarm_cfg_r;
            tsm_pkg::ADDR_STATUS: reg_rdata <= status_word;
            tsm_pkg::ADDR_MISC_CFG: reg_rdata <= misc_cfg_r;
            tsm_pkg::ADDR_TEMP_WIN: reg_rdata <= temp_win_r;
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Converter control and clocking
   // ------------------------------------------------------------
   logic enabled;
   logic [10:0] div_val;
   logic div_bypass;

   // Both disable and enable set is illegal for software; disable wins
   always_comb begin
      if (WIDE) begin
         enabled = alarm_cfg_r[tsm_pkg::W_ENABLE_BIT]
            && !alarm_cfg_r[tsm_pkg::W_DISABLE_BIT]; // [RULE7] [RULE8]
      end else begin
         enabled = !alarm_cfg_r[tsm_pkg::N_DISABLE_BIT]; // [RULE7]
      end
   end

   assign adc_attach = misc_cfg_r[tsm_pkg::ATTACH_BIT];
   assign adc_run = enabled && adc_attach && !misc_cfg_r[tsm_pkg::PAUSE_BIT]; // [RULE7]
   // Wide field zero means bypass; narrow field is a plain count
   assign div_bypass = WIDE ? (div_field_r == 7'h00) : 1'b0; // [RULE2]
   assign div_val = WIDE ? {div_field_r[6:0], 4'h0} : {4'h0, div_field_r}; // [RULE2]

   tsm_clkdiv u_div (
      .core_clk(core_clk),
      .rstn(rstn),
      .src_tick(WIDE ? const_tick : host_tick), // [RULE4]
      .bypass(div_bypass),
      .div_val(div_val),
      .adc_tick(adc_clk_en)
   );

   // ------------------------------------------------------------
   // Reading and comparisons
   // ------------------------------------------------------------
   logic signed [14:0] sum;
   logic [13:0] sum_w;
   logic signed [14:0] s_new;
   logic signed [14:0] s_alarm;
   logic signed [14:0] s_low;
   logic signed [14:0] s_high;

   always_comb begin
      sum = sfield(adc_raw) + sfield(field_at(alarm_cfg_r, tsm_pkg::OFFSET_LSB)); // [RULE5] [RULE19]
      sum_w = (RW == tsm_pkg::W_WIDTH) ? sum[13:0] : {6'h00, sum[7:0]}; // [RULE19]
      s_new = sfield(sum_w);
      s_alarm = sfield(field_at(alarm_cfg_r, 0));
      s_low = sfield(field_at(temp_win_r, 0));
      s_high = sfield(field_at(temp_win_r, WIDE ? tsm_pkg::W_HIGH_LSB : tsm_pkg::N_HIGH_LSB));
   end

   // Signed compares: the reading is two's complement like the offset
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reading_r <= 14'h0000;
         alarm_r <= 1'b0;
         low_r <= 1'b0;
         high_r <= 1'b0;
      end else if (adc_done && adc_run) begin
         reading_r <= sum_w; // [RULE5] [RULE18]
         alarm_r <= s_new > s_alarm; // [RULE11] [RULE18]
         low_r <= s_new < s_low; // [RULE12] [RULE14]
         high_r <= s_new > s_high; // [RULE13] [RULE14]
      end
   end

   assign irq_alarm = alarm_r && (WIDE || alarm_cfg_r[tsm_pkg::N_ALARM_IE_BIT]); // [RULE9] [RULE10]
   assign irq_range_low = low_r; // [RULE12]
   assign irq_range_high = high_r; // [RULE13]

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_store;
      @(posedge core_clk) disable iff (!rstn)
      adc_done && adc_run |=> reading_r == $past(sum_w);
   endproperty
   a_store: assert property (p_store) else $error("reading not stored"); // [RULE5]

   property p_alarm;
      @(posedge core_clk) disable iff (!rstn)
      adc_done && adc_run |=> alarm_r == ($past(s_new) > $past(s_alarm));
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm flag wrong"); // [RULE11]

   property p_low;
      @(posedge core_clk) disable iff (!rstn)
      adc_done && adc_run |=> irq_range_low == ($past(s_new) < $past(s_low));
   endproperty
   a_low: assert property (p_low) else $error("low range wrong"); // [RULE12]

   property p_high;
      @(posedge core_clk) disable iff (!rstn)
      adc_done && adc_run |=> irq_range_high == ($past(s_new) > $past(s_high));
   endproperty
   a_high: assert property (p_high) else $error("high range wrong"); // [RULE13]

   property p_hold;
      @(posedge core_clk) disable iff (!rstn)
      !(adc_done && adc_run) |=> $stable(reading_r) && $stable(alarm_r);
   endproperty
   a_hold: assert property (p_hold) else $error("reading moved without sample"); // [RULE18]

   property p_irq;
      @(posedge core_clk) disable iff (!rstn)
      irq_alarm |-> alarm_r
         && status_word[WIDE ? tsm_pkg::W_ALARM_STAT_BIT : tsm_pkg::N_ALARM_STAT_BIT];
   endproperty
   a_irq: assert property (p_irq) else $error("alarm interrupt without flag"); // [RULE9]

   property p_gate;
      @(posedge core_clk) disable iff (!rstn)
      !WIDE && !alarm_cfg_r[tsm_pkg::N_ALARM_IE_BIT] |-> !irq_alarm;
   endproperty
   a_gate: assert property (p_gate) else $error("alarm interrupt not gated"); // [RULE10]

   property p_unmapped;
      @(posedge core_clk) disable iff (!rstn)
      reg_rd && !in_window |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [RULE16]

   property p_div;
      @(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == tsm_pkg::ADDR_STATUS |=> div_field_r[5:0]
         == $past(reg_wdata[(WIDE ? tsm_pkg::W_DIV_LSB : tsm_pkg::N_DIV_LSB) +: tsm_pkg::W_DIV_W]);
   endproperty
   a_div: assert property (p_div) else $error("divider field not written"); // [RULE3]

   property p_range_hold;
      @(posedge core_clk) disable iff (!rstn)
      !(adc_done && adc_run) |=> $stable(irq_range_low) && $stable(irq_range_high);
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range moved"); // [RULE14]

   property p_attach;
      @(posedge core_clk) disable iff (!rstn)
      !adc_attach |-> !adc_run;
   endproperty
   a_attach: assert property (p_attach) else $error("run without sensor"); // [RULE7]

   property p_pause;
      @(posedge core_clk) disable iff (!rstn)
      misc_cfg_r[tsm_pkg::PAUSE_BIT] |-> !adc_run;
   endproperty
   a_pause: assert property (p_pause) else $error("run while paused"); // [RULE7]

   property p_disable;
      @(posedge core_clk) disable iff (!rstn)
      alarm_cfg_r[WIDE ? tsm_pkg::W_DISABLE_BIT : tsm_pkg::N_DISABLE_BIT] |-> !adc_run;
   endproperty
   a_disable: assert property (p_disable) else $error("run while disabled"); // [RULE7]

   property p_wr_cfg;
      @(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == tsm_pkg::ADDR_ALARM_CFG |=> alarm_cfg_r == $past(reg_wdata);
   endproperty
   a_wr_cfg: assert property (p_wr_cfg) else $error("alarm config not written"); // [RULE6]

   property p_wr_win;
      @(posedge core_clk) disable iff (!rstn)
      reg_wr && reg_addr == tsm_pkg::ADDR_TEMP_WIN |=> temp_win_r == $past(reg_wdata);
   endproperty
   a_wr_win: assert property (p_wr_win) else $error("window not written"); // [RULE15]

   property p_wr_outside;
      @(posedge core_clk) disable iff (!rstn)
      reg_wr && !in_window
      |=> $stable(alarm_cfg_r) && $stable(misc_cfg_r) && $stable(temp_win_r);
   endproperty
   a_wr_outside: assert property (p_wr_outside) else $error("outside write landed"); // [RULE16]

   property p_rd_cfg;
      @(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == tsm_pkg::ADDR_ALARM_CFG |=> reg_rdata == $past(alarm_cfg_r);
   endproperty
   a_rd_cfg: assert property (p_rd_cfg) else $error("alarm config read wrong"); // [RULE6]

   property p_rdata_hold;
      @(posedge core_clk) disable iff (!rstn)
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [RULE16]

   property p_sum_wrap;
      @(posedge core_clk) disable iff (!rstn)
      adc_done && adc_run
      |=> reading_r[RW-1:0] == RW'($past(adc_raw) + $past(alarm_cfg_r >> tsm_pkg::OFFSET_LSB));
   endproperty
   a_sum_wrap: assert property (p_sum_wrap) else $error("sum not wrapped"); // [RULE19]

   property p_upper;
      @(posedge core_clk) disable iff (!rstn)
      (reading_r >> RW) == 14'h0000;
   endproperty
   a_upper: assert property (p_upper) else $error("reading above field width"); // [RULE19]

   property p_reset_clear;
      @(posedge core_clk)
      !rstn |=> reading_r == 14'h0000 && !alarm_r && !low_r && !high_r;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("state not cleared"); // [RULE18]

   property p_wide_irq;
      @(posedge core_clk) disable iff (!rstn)
      WIDE |-> irq_alarm == alarm_r;
   endproperty
   a_wide_irq: assert property (p_wide_irq) else $error("alarm interrupt lost"); // [RULE9]

   property p_narrow_irq;
      @(posedge core_clk) disable iff (!rstn)
      !WIDE && alarm_cfg_r[tsm_pkg::N_ALARM_IE_BIT] |-> irq_alarm == alarm_r;
   endproperty
   a_narrow_irq: assert property (p_narrow_irq) else $error("enabled alarm lost"); // [RULE10]
endmodule

// ==== logic/tsm_pkg.sv ====
/*
 * Constants for the thermal sensor monitor: register offsets, field
 * positions and divider figures for the narrow and wide layouts.
 * Assumes a host register port with word-aligned byte addresses.
 */
package tsm_pkg;
   // ------------------------------------------------------------
   // Register window
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_ALARM_CFG = 16'h15b0;
   localparam logic [15:0] ADDR_STATUS = 16'h15b4;
   localparam logic [15:0] ADDR_MISC_CFG = 16'h15b8;
   localparam logic [15:0] ADDR_TEMP_WIN = 16'h15bc;
   localparam logic [15:0] ADDR_WIN_MASK = 16'hfff0;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OFFSET_LSB = 16;
   localparam int N_WIDTH = 8;
   localparam int W_WIDTH = 14;
   localparam int N_DISABLE_BIT = 24;
   localparam int N_ALARM_IE_BIT = 28;
   localparam int W_DISABLE_BIT = 30;
   localparam int W_ENABLE_BIT = 31;
   localparam int N_ALARM_STAT_BIT = 8;
   localparam int W_ALARM_STAT_BIT = 16;
   localparam int N_DIV_LSB = 25;
   localparam int W_DIV_LSB = 26;
   localparam int N_DIV_W = 7;
   localparam int W_DIV_W = 6;
   localparam int N_HIGH_LSB = 8;
   localparam int W_HIGH_LSB = 16;
   localparam int PAUSE_BIT = 17;
   localparam int ATTACH_BIT = 23;
   localparam int DIV_SHIFT = 4;
   // ------------------------------------------------------------
   // Divider figures
   // ------------------------------------------------------------
   localparam int PRE_DIV = 1024;
   localparam logic [10:0] PRE_DIV_LAST = 11'(PRE_DIV - 1);
   localparam logic [6:0] N_DIV_RESET = 7'h10;
   localparam logic [5:0] W_DIV_RESET = 6'h08;
endpackage

// ==== logic/tsm_clkdiv.sv ====
/*
 * Converter clock divider chain: a fixed 1024 prescaler followed by a
 * programmable divider, producing a one-cycle enable pulse.
 * Assumes src_tick marks each cycle of the chosen source clock.
 */
`timescale 1ns/1ps
module tsm_clkdiv (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic src_tick,
   input wire logic bypass,
   input wire logic [10:0] div_val,
   output logic adc_tick
);
   logic [10:0] pre_r;
   logic [10:0] prog_r;
   logic pre_tick;

   assign pre_tick = src_tick && (pre_r == tsm_pkg::PRE_DIV_LAST);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pre_r <= 11'h000;
      end else if (src_tick) begin
         pre_r <= pre_tick ? 11'h000 : pre_r + 11'h001; // [RULE1]
      end
   end

   // Divider value zero acts as one, so the pulse never stops
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         prog_r <= 11'h000;
         adc_tick <= 1'b0;
      end else begin
         adc_tick <= 1'b0;
         if (pre_tick) begin
            if (bypass || prog_r + 11'h001 >= div_val) begin // [RULE1] [RULE2]
               prog_r <= 11'h000;
               adc_tick <= 1'b1;
            end else begin
               prog_r <= prog_r + 11'h001;
            end
         end
      end
   end

   property p_tick_pre;
      @(posedge core_clk) disable iff (!rstn)
      adc_tick |-> $past(pre_tick);
   endproperty
   a_tick_pre: assert property (p_tick_pre) else $error("tick without prescale"); // [RULE1]
endmodule

// ==== testbench/tsm_adc_model.sv ====
/*
 * Converter model for the thermal sensor monitor.
 * Assumes one clock shared with the monitor; lat sets the answer delay.
 */
`timescale 1ns/1ps
module tsm_adc_model (
   input wire logic core_clk,
   input wire logic adc_clk_en,
   input wire logic adc_run,
   input wire logic adc_attach,
   input wire logic [13:0] value,
   input wire logic [3:0] lat,
   output logic adc_done,
   output logic [13:0] adc_raw
);
   logic [3:0] cnt_r = 4'h0;
   logic busy_r = 1'b0;
   initial begin
      adc_done = 1'b0;
      adc_raw = 14'h0;
   end
   always @(posedge core_clk) begin
      adc_done <= 1'b0;
      // Idle data toggles so a stale sample never looks valid
      adc_raw <= ~adc_raw;
      if (busy_r) begin
         if (cnt_r == 4'h0) begin
            adc_done <= 1'b1;
            adc_raw <= value;
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 4'h1;
         end
      end else if (adc_clk_en && adc_run && adc_attach) begin
         busy_r <= 1'b1;
         cnt_r <= lat;
      end
   end
endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for the wide and narrow monitor layouts.
 * Assumes const_tick runs every cycle; host_tick is random.
 */
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic host_tick = 1'b0;
   logic const_tick = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic [31:0] rd_v;
   logic hit_v;
   logic reg_hit, adc_clk_en, adc_run, adc_attach, adc_done;
   logic [13:0] adc_raw;
   logic [13:0] value = 14'h0;
   logic [3:0] lat = 4'h0;
   logic irq_alarm, irq_range_low, irq_range_high;
   logic [31:0] n_rdata, rd_n;
   logic n_hit, n_clk_en, n_run, n_attach, n_irq_alarm, n_irq_low, n_irq_high;
   int n_mismatch = 0;
   int n_tests = 0;
   int seed = 32'hb1dcefa5;
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) host_tick <= 1'($random(seed));
   tsm_top DUT (.core_clk(core_clk), .rstn(rstn), .host_tick(host_tick),
      .const_tick(const_tick), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .adc_clk_en(adc_clk_en), .adc_run(adc_run), .adc_attach(adc_attach),
      .adc_done(adc_done), .adc_raw(adc_raw), .irq_alarm(irq_alarm),
      .irq_range_low(irq_range_low), .irq_range_high(irq_range_high));
   tsm_top #(.WIDE(1'b0)) dut_n (.core_clk(core_clk), .rstn(rstn), .host_tick(host_tick),
      .const_tick(const_tick), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(n_rdata), .reg_hit(n_hit),
      .adc_clk_en(n_clk_en), .adc_run(n_run), .adc_attach(n_attach),
      .adc_done(adc_done), .adc_raw(adc_raw), .irq_alarm(n_irq_alarm),
      .irq_range_low(n_irq_low), .irq_range_high(n_irq_high));
   tsm_adc_model adc (.core_clk(core_clk), .adc_clk_en(adc_clk_en), .adc_run(adc_run),
      .adc_attach(adc_attach), .value(value), .lat(lat), .adc_done(adc_done),
      .adc_raw(adc_raw));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      #1 hit_v = reg_hit;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
      rd_n = n_rdata;
   endtask
   // Bounded wait for a done (sel) or a converter tick
   task automatic wait_for(input bit sel, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((sel ? adc_done : adc_clk_en) !== 1'b1 && n < 40000);
      if (n >= 40000) begin
         n_mismatch++;
         summarize();
      end
   endtask
   task automatic measure(input int exp);
      int n;
      wait_for(1'b0, n);
      wait_for(1'b0, n);
      check(32'(n), 32'(exp));
   endtask
   function automatic int sx(input int v);
      return ((v & 16383) >= 8192) ? (v & 16383) - 16384 : (v & 16383);
   endfunction
   function automatic int sx8(input int v);
      return ((v & 255) >= 128) ? (v & 255) - 256 : (v & 255);
   endfunction
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int raw, off, thr, lo, hi, rdg, n;
      logic al;
      int nrd, nal;
      nrd = 0;
      nal = 0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      rd(tsm_pkg::ADDR_STATUS);
      check(rd_v, {6'h08, 26'h0});
      check(rd_n, {7'h10, 25'h0});
      rd(16'h15c0);
      check(hit_v, 1'b0);
      check(rd_v, 32'h0);
      rd(tsm_pkg::ADDR_TEMP_WIN);
      check(hit_v, 1'b1);
      check(rd_v, 32'h0);
      wr(16'h15c0, 32'hffff_ffff);
      rd(tsm_pkg::ADDR_ALARM_CFG);
      check(rd_v, 32'h0);
      wr(tsm_pkg::ADDR_MISC_CFG, 32'h0082_0000);
      #1 check({adc_run, adc_attach}, 2'b01);
      wr(tsm_pkg::ADDR_MISC_CFG, 32'h0080_0000);
      wr(tsm_pkg::ADDR_ALARM_CFG, 32'h4000_0000);
      #1 check({adc_run, adc_attach}, 2'b01);
      wr(tsm_pkg::ADDR_ALARM_CFG, 32'h8000_0000);
      #1 check({adc_run, adc_attach}, 2'b11);
      wr(tsm_pkg::ADDR_MISC_CFG, 32'h0082_0000);
      #1 check(adc_run, 1'b0);
      wr(tsm_pkg::ADDR_MISC_CFG, 32'h0080_0000);
      wr(tsm_pkg::ADDR_STATUS, 32'h0);
      measure(1024);
      for (int i = 0; i < 12; i++) begin
         raw = $random(seed) & 16383;
         off = $random(seed) & 16383;
         rdg = sx(raw + off);
         thr = (i == 0) ? rdg : sx($random(seed));
         lo = (i == 0) ? rdg : sx($random(seed));
         hi = (i == 0) ? rdg : sx($random(seed));
         wr(tsm_pkg::ADDR_ALARM_CFG, {2'b10, 14'(off), 2'b0, 14'(thr)});
         wr(tsm_pkg::ADDR_TEMP_WIN, {2'b0, 14'(hi), 2'b0, 14'(lo)});
         value <= 14'(raw);
         lat <= 4'(i);
         wait_for(1'b0, n);
         wait_for(1'b1, n);
         #1 al = rdg > thr;
         check(irq_alarm, al);
         check({irq_range_low, irq_range_high}, {rdg < lo, rdg > hi});
         rd(tsm_pkg::ADDR_STATUS);
         check(rd_v, {15'h0, al, 2'b0, 14'(rdg)});
         // Narrow layout disables itself when offset bit 8 lands on its disable bit
         if (off[8] == 1'b0) begin
            nrd = (raw + off) & 255;
            nal = int'(sx8(nrd) > sx8(thr));
         end
         check(n_irq_alarm, 1'(nal) & off[12]);
         check(rd_n, {23'h0, 1'(nal), 8'(nrd)});
      end
      wr(tsm_pkg::ADDR_STATUS, {6'h02, 26'h0});
      measure(32 * 1024);
      rd(tsm_pkg::ADDR_STATUS);
      check(rd_v[31:26], 6'h02);
      summarize();
   end
endmodule
